// File: include/tdos_regs.vh
// register map, field positions and timing counts of the output sequencer
// assumes a 25 MHz system clock and a word-aligned register port
`ifndef TDOS_REGS_VH
`define TDOS_REGS_VH

`define TDOS_AW            10
`define TDOS_DW            32
`define TDOS_TW            22

`define TDOS_CLK_NS        40
`define TDOS_TENTH_NS      100000000
`define TDOS_TICK_CYCLES   (`TDOS_TENTH_NS / `TDOS_CLK_NS)
`define TDOS_DUR_MAX       22'h36EE7F

`define TDOS_OFF_CTRL      10'h000
`define TDOS_OFF_CYCLES    10'h004
`define TDOS_OFF_STATUS    10'h008
`define TDOS_OFF_SEG_REM   10'h00C
`define TDOS_OFF_IRQ_STAT  10'h010
`define TDOS_OFF_IRQ_MASK  10'h014
`define TDOS_OFF_DUR_BASE  2'b01

`define TDOS_CTRL_RUN      0
`define TDOS_CTRL_RDIS     1
`define TDOS_CTRL_GATE     2
`define TDOS_CTRL_PFAIL    3
`define TDOS_CTRL_SEL_LO   4
`define TDOS_CTRL_MAX_LO   6

`define TDOS_IRQ_STEP      0
`define TDOS_IRQ_END       1
`define TDOS_IRQ_RANGE     2

`define TDOS_CTRL_RESET    8'hC0
`define TDOS_CYCLES_CONT   10'h000
`define TDOS_CYCLES_MAX    10'h3E7

`endif

// File: testbench/tb_timed_digital_output_sequencer.sv
// self-checking bench for the output sequencer
// assumes tdos_top with a short tick and the plain register port
`timescale 1ns/1ps
`include "tdos_regs.vh"
module tb_timed_digital_output_sequencer;
  localparam TK = 10;
  reg         clk = 1'b0;
  reg         rst_n = 1'b0;
  reg  [9:0]  addr = 10'h000;
  reg  [31:0] wdata = 32'h0;
  reg         wr = 1'b0;
  reg         rd = 1'b0;
  wire [31:0] rdata;
  reg  [5:0]  wires = 6'h00;
  reg         pwr = 1'b0;
  reg  [31:0] rv;
  wire        dout, dout_n, pend, irq;
  integer     fail_count = 0;
  integer     n_tests = 0;
  always #20 clk = ~clk;
  tdos_top #(.TICK_CYCLES(TK)) i_dut (.SYS_CLK_I(clk), .RST_N_I(rst_n),
    .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
    .RUN_HOLD_WIRE_EN_I(wires[5]), .RUN_HOLD_WIRE_I(wires[4]),
    .RESET_DIS_WIRE_EN_I(wires[3]), .RESET_DIS_WIRE_I(wires[2]),
    .OUTPUT_GATE_WIRE_EN_I(wires[1]), .OUTPUT_GATE_WIRE_SOURCE_I(wires[0]),
    .POWER_RESTORED_I(pwr), .DOUT_O(dout), .DOUT_INV_O(dout_n),
    .PROG_END_O(pend), .IRQ_O(irq));
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  // strobe dropped a full cycle before the next use, never twice a step
  task wr_reg(input [9:0] a, input [31:0] d);
    begin
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
    end
  endtask
  task rd_reg(input [9:0] a);
    begin
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 rv = rdata;
      @(posedge clk);
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  initial begin : watchdog
    #(40 * 20000);
    fail_count = fail_count + 1;
    finish_test;
  end
  initial begin : main
    integer i, hc, lc, d1, d2, seed;
    seed = $urandom(17397);
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd_reg(`TDOS_OFF_CTRL);
    chk(rv, 32'hC0);
    rd_reg(`TDOS_OFF_CYCLES);
    chk(rv, 32'h0);
    rd_reg(10'h018);
    chk(rv, 32'h0);
    wr_reg(`TDOS_OFF_CYCLES, 32'h3FF);
    rd_reg(`TDOS_OFF_CYCLES);
    chk(rv, 32'h3E7);
    wr_reg(10'h100, 32'h3FFFFF);
    wr_reg(`TDOS_OFF_IRQ_MASK, 32'h4);
    rd_reg(10'h100);
    chk(rv, 32'h36EE7F);
    chk(irq, 1);
    wr_reg(`TDOS_OFF_IRQ_STAT, 32'h4);
    @(posedge clk);
    chk(irq, 0);
    d1 = 1 + $urandom % 3;
    d2 = 1 + $urandom % 3;
    // program 1 only; select 3 above limit 1, program 3 stays all zero
    wr_reg(10'h140, d1);
    wr_reg(10'h14C, d2);
    wr_reg(`TDOS_OFF_CYCLES, 32'h1);
    wr_reg(`TDOS_OFF_IRQ_MASK, 32'h2);
    wr_reg(`TDOS_OFF_CTRL, 32'h77);
    hc = 0;
    lc = 0;
    for (i = 0; i < 2000 && !pend; i = i + 1) begin
      @(posedge clk);
      if (i == 6)
        wires <= 6'b101111;
      if (i == 26)
        wires <= 6'b000000;
      #1;
      if (i == 20)
        chk(dout, 1);
      if (i < 6 || i > 28) begin
        if (dout)
          hc = hc + 1;
        else if (hc > 0)
          lc = lc + 1;
      end
    end
    chk((hc + TK / 2) / TK, d1);
    chk(lc >= d2 * TK && lc <= d2 * TK + 24, 1);
    chk(pend, 1);
    @(posedge clk);
    rd_reg(`TDOS_OFF_IRQ_STAT);
    chk(rv, 32'h3);
    chk(irq, 1);
    wires <= 6'b001100;
    repeat (4) @(posedge clk);
    chk(pend, 1);
    wires <= 6'b001000;
    repeat (4) @(posedge clk);
    chk(pend, 0);
    wires <= 6'b000010;
    repeat (30) @(posedge clk);
    chk(dout, 0);
    wires <= 6'b110000;
    wr_reg(`TDOS_OFF_CTRL, 32'h7F);
    pwr <= 1'b1;
    @(posedge clk);
    pwr <= 1'b0;
    @(posedge clk);
    rd_reg(`TDOS_OFF_CTRL);
    chk(rv, 32'h7C);
    rd_reg(`TDOS_OFF_STATUS);
    chk(rv & 32'h18, 32'h10);
    finish_test;
  end
endmodule // tb_timed_digital_output_sequencer

// File: testbench/tdos_top_sva.sv
// port assertions for the output sequencer
// assumes one clock domain, bound into tdos_top
`timescale 1ns/1ps
module tdos_top_sva #(
  parameter TICK_CYCLES = 10
) (
  input wire        SYS_CLK_I,
  input wire        RST_N_I,
  input wire [9:0]  ADDR_I,
  input wire [31:0] WDATA_I,
  input wire        WR_I,
  input wire        RD_I,
  input wire [31:0] RDATA_O,
  input wire        RUN_HOLD_WIRE_I,
  input wire        RUN_HOLD_WIRE_EN_I,
  input wire        RESET_DIS_WIRE_I,
  input wire        RESET_DIS_WIRE_EN_I,
  input wire        OUTPUT_GATE_WIRE_SOURCE_I,
  input wire        OUTPUT_GATE_WIRE_EN_I,
  input wire        POWER_RESTORED_I,
  input wire        DOUT_O,
  input wire        DOUT_INV_O,
  input wire        PROG_END_O,
  input wire        IRQ_O
);
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (!RST_N_I);
  AST_INV: assert property (DOUT_INV_O == !DOUT_O)
    else $error("inverted output view differs");
  AST_RD_IDLE: assert property (!$past(RD_I) |-> RDATA_O == 32'h0)
    else $error("read data outside read slot");
  AST_GATE: assert property (
    (OUTPUT_GATE_WIRE_EN_I && !OUTPUT_GATE_WIRE_SOURCE_I)[*3] |-> !DOUT_O)
    else $error("output high while gate off");
  AST_RDIS_OUT: assert property (
    (RESET_DIS_WIRE_EN_I && !RESET_DIS_WIRE_I)[*3] |-> !DOUT_O)
    else $error("output high while held in reset");
  AST_RDIS_END: assert property (
    (RESET_DIS_WIRE_EN_I && !RESET_DIS_WIRE_I)[*3] |-> !PROG_END_O)
    else $error("end flag high while held in reset");
  AST_HOLD: assert property (
    (RUN_HOLD_WIRE_EN_I && !RUN_HOLD_WIRE_I && RESET_DIS_WIRE_EN_I &&
     RESET_DIS_WIRE_I && OUTPUT_GATE_WIRE_EN_I &&
     OUTPUT_GATE_WIRE_SOURCE_I)[*3] |-> $stable(DOUT_O))
    else $error("output moved during hold");
  AST_END_KEEP: assert property (
    PROG_END_O && RESET_DIS_WIRE_EN_I && RESET_DIS_WIRE_I |=> PROG_END_O)
    else $error("end flag dropped while enabled");
  AST_END_LOW: assert property (PROG_END_O[*2] |-> !DOUT_O)
    else $error("output high after completion");
endmodule // tdos_top_sva
bind tdos_top tdos_top_sva #(.TICK_CYCLES(TICK_CYCLES)) i_sva (
  .SYS_CLK_I(SYS_CLK_I), .RST_N_I(RST_N_I), .ADDR_I(ADDR_I),
  .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
  .RUN_HOLD_WIRE_I(RUN_HOLD_WIRE_I), .RUN_HOLD_WIRE_EN_I(RUN_HOLD_WIRE_EN_I),
  .RESET_DIS_WIRE_I(RESET_DIS_WIRE_I),
  .RESET_DIS_WIRE_EN_I(RESET_DIS_WIRE_EN_I),
  .OUTPUT_GATE_WIRE_SOURCE_I(OUTPUT_GATE_WIRE_SOURCE_I),
  .OUTPUT_GATE_WIRE_EN_I(OUTPUT_GATE_WIRE_EN_I),
  .POWER_RESTORED_I(POWER_RESTORED_I), .DOUT_O(DOUT_O),
  .DOUT_INV_O(DOUT_INV_O), .PROG_END_O(PROG_END_O), .IRQ_O(IRQ_O));

// File: verilog/tdos_top.v
// timed digital output sequencer: four programs of eight on/off pairs
// assumes synchronous inputs, plain register port, wired sources optional
//
// Overview of operation
// - each program holds eight numbered on/off pairs
// - four programs stored, selection chooses one
// - upper limit 0..3 bounds program selection
// - sequence starts with first on-period
// - zero-length periods are skipped
// - after eighth off-period, return to start
// - durations 0 to 99:59:59.9, tenths, range flagged
// - run advances timing, hold freezes it
// - reset-disable off holds program in reset
// - cycle count continuous or up to 999
// - output state and its inverse readable
// - end flag off running, on complete
// - power-fail recovery forces hold and reset
// - wired controls override power-up recovery state
// - starts in any programmer segment or standalone
//
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/1ps
`include "tdos_regs.vh"

module tdos_top #(
  parameter TICK_CYCLES = `TDOS_TICK_CYCLES
) (
  input  wire                 SYS_CLK_I,
  input  wire                 RST_N_I,
  input  wire [`TDOS_AW-1:0]  ADDR_I,
  input  wire [`TDOS_DW-1:0]  WDATA_I,
  input  wire                 WR_I,
  input  wire                 RD_I,
  output reg  [`TDOS_DW-1:0]  RDATA_O,
  input  wire                 RUN_HOLD_WIRE_I,
  input  wire                 RUN_HOLD_WIRE_EN_I,
  input  wire                 RESET_DIS_WIRE_I,
  input  wire                 RESET_DIS_WIRE_EN_I,
  input  wire                 OUTPUT_GATE_WIRE_SOURCE_I,
  input  wire                 OUTPUT_GATE_WIRE_EN_I,
  input  wire                 POWER_RESTORED_I,
  output reg                  DOUT_O,
  output reg                  DOUT_INV_O,
  output reg                  PROG_END_O,
  output reg                  IRQ_O
);

  localparam ST_LOAD = 1'b0;
  localparam ST_TIME = 1'b1;

  reg  [7:0]          ctrl;
  reg  [9:0]          cycles_set;
  reg  [2:0]          irq_stat;
  reg  [2:0]          irq_mask;
  reg                 state;
  reg  [3:0]          step;
  reg  [`TDOS_TW-1:0] seg_rem;
  reg  [9:0]          cycles_done;
  reg                 done;
  reg                 seq_out;
  reg  [21:0]         tick_cnt;
  reg                 ev_step;
  reg                 ev_end;

  wire [`TDOS_TW-1:0] dur [0:63];
  wire                dur_wr;
  wire                range_err;
  wire                eff_run;
  wire                eff_rdis;
  wire                eff_gate;
  wire [1:0]          sel_req;
  wire [1:0]          sel_max;
  wire [1:0]          sel_eff;
  wire [`TDOS_TW-1:0] cur_dur;
  wire                tick;
  wire                wrap;
  wire [9:0]          next_cycles_done;
  wire                last_cycle;

  // durations live in flops; a write above the limit is clamped
  assign dur_wr    = WR_I && (ADDR_I[9:8] == `TDOS_OFF_DUR_BASE)
                     && (ADDR_I[1:0] == 2'b00);
  assign range_err = dur_wr && (WDATA_I > {10'h000, `TDOS_DUR_MAX});

  genvar g;
  generate
    for (g = 0; g < 64; g = g + 1) begin : g_dur
      reg [`TDOS_TW-1:0] val;
      always @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
          val <= {`TDOS_TW{1'b0}};
        end else if (dur_wr && ADDR_I[7:2] == g) begin
          if (range_err) begin
            val <= `TDOS_DUR_MAX;
          end else begin
            val <= WDATA_I[`TDOS_TW-1:0];
          end
        end
      end
      assign dur[g] = val;
    end
  endgenerate

  // wired sources win over settings
  assign eff_run  = RUN_HOLD_WIRE_EN_I ? RUN_HOLD_WIRE_I :
                    ctrl[`TDOS_CTRL_RUN];
  assign eff_rdis = RESET_DIS_WIRE_EN_I ? RESET_DIS_WIRE_I :
                    ctrl[`TDOS_CTRL_RDIS];
  assign eff_gate = OUTPUT_GATE_WIRE_EN_I ? OUTPUT_GATE_WIRE_SOURCE_I :
                    ctrl[`TDOS_CTRL_GATE];

  assign sel_req = ctrl[`TDOS_CTRL_SEL_LO+1:`TDOS_CTRL_SEL_LO];
  assign sel_max = ctrl[`TDOS_CTRL_MAX_LO+1:`TDOS_CTRL_MAX_LO];
  assign sel_eff = (sel_req > sel_max) ? sel_max : sel_req;
  assign cur_dur = dur[{sel_eff, step}];

  assign tick = (tick_cnt == TICK_CYCLES - 1);
  assign wrap = (step == 4'hF);
  assign next_cycles_done = cycles_done + 10'h001;
  assign last_cycle = (cycles_set != `TDOS_CYCLES_CONT)
                      && (next_cycles_done == cycles_set);

  // settings register; power restore may force hold and reset
  always @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ctrl       <= `TDOS_CTRL_RESET;
      cycles_set <= `TDOS_CYCLES_CONT;
    end else if (POWER_RESTORED_I && ctrl[`TDOS_CTRL_PFAIL]) begin
      ctrl[`TDOS_CTRL_RUN]  <= 1'b0;
      ctrl[`TDOS_CTRL_RDIS] <= 1'b0;
    end else if (WR_I && ADDR_I == `TDOS_OFF_CTRL) begin
      ctrl <= WDATA_I[7:0];
    end else if (WR_I && ADDR_I == `TDOS_OFF_CYCLES) begin
      if (WDATA_I[9:0] > `TDOS_CYCLES_MAX) begin
        cycles_set <= `TDOS_CYCLES_MAX;
      end else begin
        cycles_set <= WDATA_I[9:0];
      end
    end
  end

  // tenth-second prescaler, frozen outside run
  always @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      tick_cnt <= 22'h000000;
    end else if (!eff_rdis || state != ST_TIME) begin
      tick_cnt <= 22'h000000;
    end else if (eff_run && !done) begin
      if (tick) begin
        tick_cnt <= 22'h000000;
      end else begin
        tick_cnt <= tick_cnt + 22'h000001;
      end
    end
  end

  // step sequencer; a zero step costs one clock, never a tick
  always @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state       <= ST_LOAD;
      step        <= 4'h0;
      seg_rem     <= {`TDOS_TW{1'b0}};
      cycles_done <= 10'h000;
      done        <= 1'b0;
      seq_out     <= 1'b0;
      ev_step     <= 1'b0;
      ev_end      <= 1'b0;
    end else begin
      ev_step <= 1'b0;
      ev_end  <= 1'b0;
      if (!eff_rdis) begin
        state       <= ST_LOAD;
        step        <= 4'h0;
        seg_rem     <= {`TDOS_TW{1'b0}};
        cycles_done <= 10'h000;
        done        <= 1'b0;
        seq_out     <= 1'b0;
      end else if (eff_run && !done) begin
        case (state)
          ST_LOAD: begin
            if (cur_dur != {`TDOS_TW{1'b0}}) begin
              seg_rem <= cur_dur;
              seq_out <= ~step[0];
              state   <= ST_TIME;
              ev_step <= 1'b1;
            end else begin
              step <= step + 4'h1;
              if (wrap) begin
                cycles_done <= next_cycles_done;
                if (last_cycle) begin
                  done    <= 1'b1;
                  seq_out <= 1'b0;
                  ev_end  <= 1'b1;
                end
              end
            end
          end
          ST_TIME: begin
            if (tick) begin
              seg_rem <= seg_rem - {{(`TDOS_TW-1){1'b0}}, 1'b1};
              if (seg_rem == {{(`TDOS_TW-1){1'b0}}, 1'b1}) begin
                state <= ST_LOAD;
                step  <= step + 4'h1;
                if (wrap) begin
                  cycles_done <= next_cycles_done;
                  if (last_cycle) begin
                    done    <= 1'b1;
                    seq_out <= 1'b0;
                    ev_end  <= 1'b1;
                  end
                end
              end
            end
          end
          default: begin
            state <= ST_LOAD;
          end
        endcase
      end
    end
  end

  // sticky events, set wins over a write-one clear
  always @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      irq_stat <= 3'h0;
      irq_mask <= 3'h0;
    end else begin
      if (WR_I && ADDR_I == `TDOS_OFF_IRQ_MASK) begin
        irq_mask <= WDATA_I[2:0];
      end
      irq_stat <= ((WR_I && ADDR_I == `TDOS_OFF_IRQ_STAT) ?
                   (irq_stat & ~WDATA_I[2:0]) : irq_stat)
                  | {range_err, ev_end, ev_step};
    end
  end

  // registered pins; inverse view tracks the gated pin
  always @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      DOUT_O     <= 1'b0;
      DOUT_INV_O <= 1'b1;
      PROG_END_O <= 1'b0;
      IRQ_O      <= 1'b0;
    end else begin
      DOUT_O     <= seq_out & eff_gate;
      DOUT_INV_O <= ~(seq_out & eff_gate);
      PROG_END_O <= done;
      IRQ_O      <= |(irq_stat & irq_mask);
    end
  end

  // read port, data in the cycle after the strobe, unmapped reads zero
  always @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      RDATA_O <= 32'h00000000;
    end else if (RD_I) begin
      if (ADDR_I == `TDOS_OFF_CTRL) begin
        RDATA_O <= {24'h000000, ctrl};
      end else if (ADDR_I == `TDOS_OFF_CYCLES) begin
        RDATA_O <= {22'h000000, cycles_set};
      end else if (ADDR_I == `TDOS_OFF_STATUS) begin
        RDATA_O <= {6'h00, cycles_done, 4'h0, step, 3'h0, eff_run,
                    eff_rdis, done, ~seq_out, seq_out};
      end else if (ADDR_I == `TDOS_OFF_SEG_REM) begin
        RDATA_O <= {10'h000, seg_rem};
      end else if (ADDR_I == `TDOS_OFF_IRQ_STAT) begin
        RDATA_O <= {29'h00000000, irq_stat};
      end else if (ADDR_I == `TDOS_OFF_IRQ_MASK) begin
        RDATA_O <= {29'h00000000, irq_mask};
      end else if (ADDR_I[9:8] == `TDOS_OFF_DUR_BASE
                   && ADDR_I[1:0] == 2'b00) begin
        RDATA_O <= {10'h000, dur[ADDR_I[7:2]]};
      end else begin
        RDATA_O <= 32'h00000000;
      end
    end else begin
      RDATA_O <= 32'h00000000;
    end
  end

endmodule // tdos_top
